/* File: logic/drp_ctrl.sv */
// Behaviour
// R01 - Left field routes mixer, line, direct path
// R02 - Right field routes mixer, line, direct path
// R03 - Software never writes switch code 11
// R04 - Link field selects which channel follows which
// R05 - Link code 11 acts like 00
// R06 - Direct path adds one decibel attenuation
// R07 - Four-bit code sets driver power-on delay
// R08 - Software never writes delay codes 1100-1111
// R09 - Two-bit code sets ramp step time
// R10 - One bit selects weak common-mode source
// R11 - Software writes zero to lowest pop bit
// R12 - Left mute bit, resets muted
// R13 - Left attenuation in half-decibel steps, resets zero
// R14 - Switch and pop registers reset to zero
// R15 - Right volume register, mute resets to one
// R16 - Following channel uses followed register entirely
`timescale 1ns/1ps
`default_nettype none
module drp_ctrl
  import drp_pkg::*;
#(
  parameter int P_DLY_100_US = CYC_100_US,
  parameter int P_DLY_10_MS  = CYC_10_MS,
  parameter int P_DLY_20_MS  = CYC_20_MS,
  parameter int P_DLY_50_MS  = CYC_50_MS,
  parameter int P_DLY_100_MS = CYC_100_MS,
  parameter int P_DLY_200_MS = CYC_200_MS,
  parameter int P_DLY_400_MS = CYC_400_MS,
  parameter int P_DLY_800_MS = CYC_800_MS,
  parameter int P_DLY_2_S    = CYC_2_S,
  parameter int P_DLY_4_S    = CYC_4_S,
  parameter int P_STEP_1_MS  = CYC_1_MS,
  parameter int P_STEP_2_MS  = CYC_2_MS,
  parameter int P_STEP_4_MS  = CYC_4_MS
) (
  // Clock, reset and enable
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       ce,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Driver power sequencing
  input  wire logic       drv_power_req,
  output logic            drv_ramp_step,
  output logic            drv_ready,
  // Output routing
  output logic            left_mixer_path,
  output logic            left_line_path,
  output logic            left_direct_hp_path,
  output logic            right_mixer_path,
  output logic            right_line_path,
  output logic            right_direct_hp_path,
  output logic            vcm_from_bandgap,
  // Effective digital volume, attenuation in 0.5 dB units
  output logic            left_mute,
  output logic      [7:0] left_atten,
  output logic            right_mute,
  output logic      [7:0] right_atten
);

  logic [7:0]    switch_q;
  logic [7:0]    pop_q;
  logic [7:0]    lvol_q;
  logic [7:0]    rvol_q;
  drp_state_type state_q;
  logic [31:0]   timer_q;
  logic [3:0]    steps_q;

  // Power-on delay per code; reserved codes fall back to the longest delay.
  function automatic logic [31:0] delay_cycles(input logic [3:0] code);
    unique case (code)
      4'h0:    delay_cycles = 32'h0;
      4'h1:    delay_cycles = 32'(CYC_10_US);
      4'h2:    delay_cycles = 32'(P_DLY_100_US);
      4'h3:    delay_cycles = 32'(P_DLY_10_MS);
      4'h4:    delay_cycles = 32'(P_DLY_20_MS);
      4'h5:    delay_cycles = 32'(P_DLY_50_MS);
      4'h6:    delay_cycles = 32'(P_DLY_100_MS);
      4'h7:    delay_cycles = 32'(P_DLY_200_MS);
      4'h8:    delay_cycles = 32'(P_DLY_400_MS);
      4'h9:    delay_cycles = 32'(P_DLY_800_MS);
      4'hA:    delay_cycles = 32'(P_DLY_2_S);
      default: delay_cycles = 32'(P_DLY_4_S);
    endcase
  endfunction : delay_cycles

  function automatic logic [31:0] step_cycles(input logic [1:0] code);
    unique case (code)
      2'h0: step_cycles = 32'h0;
      2'h1: step_cycles = 32'(P_STEP_1_MS);
      2'h2: step_cycles = 32'(P_STEP_2_MS);
      2'h3: step_cycles = 32'(P_STEP_4_MS);
    endcase
  endfunction : step_cycles

  // Attenuation with the direct-path extra loss folded in.
  function automatic logic [7:0] eff_atten(input logic [7:0] vol, input logic [1:0] path);
    eff_atten = {1'b0, vol[VOL_ATT_HI:0]};
    if (path == PATH_DIRECT) begin
      eff_atten = eff_atten + DIRECT_EXTRA_ATT; // see R06
    end
  endfunction : eff_atten

  // Register writes; reserved bits are stored as written since they are R/W.
  always_ff @(posedge mclk) begin
    if (srst) begin
      switch_q <= RST_SWITCH; // see R14
      pop_q    <= RST_POP;    // see R14
      lvol_q   <= RST_VOL;    // see R12 see R13
      rvol_q   <= RST_VOL;    // see R15
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        ADDR_SWITCH:    switch_q <= reg_wdata; // see R03
        ADDR_POP:       pop_q    <= reg_wdata; // see R11
        ADDR_LEFT_VOL:  lvol_q   <= reg_wdata;
        ADDR_RIGHT_VOL: rvol_q   <= reg_wdata;
        default:        ;
      endcase
    end
  end

  // Read data is registered; unmapped addresses read as zero.
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      unique case (reg_addr)
        ADDR_SWITCH:    reg_rdata <= switch_q;
        ADDR_POP:       reg_rdata <= pop_q;
        ADDR_LEFT_VOL:  reg_rdata <= lvol_q;
        ADDR_RIGHT_VOL: reg_rdata <= rvol_q;
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

  // Path decode; a stray code 11 selects no path at all.
  always_ff @(posedge mclk) begin
    if (srst) begin
      left_mixer_path      <= 1'b1;
      left_line_path       <= 1'b0;
      left_direct_hp_path  <= 1'b0;
      right_mixer_path     <= 1'b1;
      right_line_path      <= 1'b0;
      right_direct_hp_path <= 1'b0;
      vcm_from_bandgap     <= 1'b0;
    end else if (ce) begin
      left_mixer_path      <= switch_q[SW_LEFT_HI:SW_LEFT_LO] == PATH_MIXER;    // see R01
      left_line_path       <= switch_q[SW_LEFT_HI:SW_LEFT_LO] == PATH_LINE;     // see R01
      left_direct_hp_path  <= switch_q[SW_LEFT_HI:SW_LEFT_LO] == PATH_DIRECT;   // see R01
      right_mixer_path     <= switch_q[SW_RIGHT_HI:SW_RIGHT_LO] == PATH_MIXER;  // see R02
      right_line_path      <= switch_q[SW_RIGHT_HI:SW_RIGHT_LO] == PATH_LINE;   // see R02
      right_direct_hp_path <= switch_q[SW_RIGHT_HI:SW_RIGHT_LO] == PATH_DIRECT; // see R02
      vcm_from_bandgap     <= pop_q[POP_VCM_BIT]; // see R10
    end
  end

  // Effective volume per channel; only codes 01 and 10 link, so 11 stays independent.
  always_ff @(posedge mclk) begin
    if (srst) begin
      left_mute   <= 1'b1;
      left_atten  <= 8'h00;
      right_mute  <= 1'b1;
      right_atten <= 8'h00;
    end else if (ce) begin
      if (switch_q[SW_LINK_HI:SW_LINK_LO] == LINK_LEFT_FOLLOWS) begin
        left_mute  <= rvol_q[VOL_MUTE_BIT]; // see R04 see R15 see R16
        left_atten <= eff_atten(rvol_q, switch_q[SW_LEFT_HI:SW_LEFT_LO]);
      end else begin
        left_mute  <= lvol_q[VOL_MUTE_BIT]; // see R05 see R12
        left_atten <= eff_atten(lvol_q, switch_q[SW_LEFT_HI:SW_LEFT_LO]); // see R13
      end
      if (switch_q[SW_LINK_HI:SW_LINK_LO] == LINK_RIGHT_FOLLOWS) begin
        right_mute  <= lvol_q[VOL_MUTE_BIT]; // see R04 see R16
        right_atten <= eff_atten(lvol_q, switch_q[SW_RIGHT_HI:SW_RIGHT_LO]);
      end else begin
        right_mute  <= rvol_q[VOL_MUTE_BIT]; // see R05 see R15
        right_atten <= eff_atten(rvol_q, switch_q[SW_RIGHT_HI:SW_RIGHT_LO]);
      end
    end
  end

  // Driver power-on: wait the delay, then step the ramp a fixed number of times.
  // Dropping the request at any point powers the driver back down at once.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q       <= DRP_IDLE;
      timer_q       <= 32'h0;
      steps_q       <= 4'h0;
      drv_ramp_step <= 1'b0;
      drv_ready     <= 1'b0;
    end else if (ce) begin
      drv_ramp_step <= 1'b0;
      if (!drv_power_req) begin
        state_q   <= DRP_IDLE;
        drv_ready <= 1'b0;
      end else begin
        unique case (state_q)
          DRP_IDLE: begin
            timer_q <= delay_cycles(pop_q[POP_DLY_HI:POP_DLY_LO]); // see R07 see R08
            state_q <= DRP_DELAY;
          end
          DRP_DELAY: begin
            if (timer_q == 32'h0) begin
              timer_q <= step_cycles(pop_q[POP_STEP_HI:POP_STEP_LO]); // see R09
              steps_q <= RAMP_STEPS;
              state_q <= DRP_RAMP;
            end else begin
              timer_q <= timer_q - 32'h1;
            end
          end
          DRP_RAMP: begin
            if (steps_q == 4'h0) begin
              state_q   <= DRP_READY;
              drv_ready <= 1'b1;
            end else if (timer_q == 32'h0) begin
              drv_ramp_step <= 1'b1;
              steps_q       <= steps_q - 4'h1;
              timer_q       <= step_cycles(pop_q[POP_STEP_HI:POP_STEP_LO]); // see R09
            end else begin
              timer_q <= timer_q - 32'h1;
            end
          end
          DRP_READY: drv_ready <= 1'b1;
        endcase
      end
    end
  end

endmodule : drp_ctrl
`default_nettype wire

/* File: inc/drp_pkg.sv */
`default_nettype none
package drp_pkg;

  // Register addresses on the control port.
  localparam logic [7:0] ADDR_SWITCH   = 8'h29;
  localparam logic [7:0] ADDR_POP      = 8'h2A;
  localparam logic [7:0] ADDR_LEFT_VOL = 8'h2B;
  localparam logic [7:0] ADDR_RIGHT_VOL = 8'h2C;

  // Reset values.
  localparam logic [7:0] RST_SWITCH    = 8'h00;
  localparam logic [7:0] RST_POP       = 8'h00;
  localparam logic [7:0] RST_VOL       = 8'h80;

  // Switch register fields.
  localparam int SW_LEFT_HI    = 7;
  localparam int SW_LEFT_LO    = 6;
  localparam int SW_RIGHT_HI   = 5;
  localparam int SW_RIGHT_LO   = 4;
  localparam int SW_LINK_HI    = 1;
  localparam int SW_LINK_LO    = 0;

  // Pop reduction register fields.
  localparam int POP_DLY_HI    = 7;
  localparam int POP_DLY_LO    = 4;
  localparam int POP_STEP_HI   = 3;
  localparam int POP_STEP_LO   = 2;
  localparam int POP_VCM_BIT   = 1;

  // Volume register fields.
  localparam int VOL_MUTE_BIT  = 7;
  localparam int VOL_ATT_HI    = 6;

  // Path codes of a channel switch field.
  localparam logic [1:0] PATH_MIXER  = 2'h0;
  localparam logic [1:0] PATH_LINE   = 2'h1;
  localparam logic [1:0] PATH_DIRECT = 2'h2;

  // Volume linking codes.
  localparam logic [1:0] LINK_LEFT_FOLLOWS  = 2'h1;
  localparam logic [1:0] LINK_RIGHT_FOLLOWS = 2'h2;

  // Extra attenuation on the direct path, in 0.5 dB units (1 dB).
  localparam logic [7:0] DIRECT_EXTRA_ATT = 8'h02;

  // Clock rate and the printed times.
  localparam int CLK_MHZ       = 125;
  localparam int T_10_US       = 10;
  localparam int T_100_US      = 100;
  localparam int T_10_MS       = 10;
  localparam int T_20_MS       = 20;
  localparam int T_50_MS       = 50;
  localparam int T_100_MS      = 100;
  localparam int T_200_MS      = 200;
  localparam int T_400_MS      = 400;
  localparam int T_800_MS      = 800;
  localparam int T_2_S         = 2;
  localparam int T_4_S         = 4;
  localparam int T_1_MS        = 1;
  localparam int T_2_MS        = 2;
  localparam int T_4_MS        = 4;

  // Cycle counts derived from the times.
  localparam int CYC_PER_US    = CLK_MHZ;
  localparam int CYC_PER_MS    = CLK_MHZ * 1000;
  localparam int CYC_10_US     = T_10_US * CYC_PER_US;
  localparam int CYC_100_US    = T_100_US * CYC_PER_US;
  localparam int CYC_10_MS     = T_10_MS * CYC_PER_MS;
  localparam int CYC_20_MS     = T_20_MS * CYC_PER_MS;
  localparam int CYC_50_MS     = T_50_MS * CYC_PER_MS;
  localparam int CYC_100_MS    = T_100_MS * CYC_PER_MS;
  localparam int CYC_200_MS    = T_200_MS * CYC_PER_MS;
  localparam int CYC_400_MS    = T_400_MS * CYC_PER_MS;
  localparam int CYC_800_MS    = T_800_MS * CYC_PER_MS;
  localparam int CYC_2_S       = T_2_S * 1000 * CYC_PER_MS;
  localparam int CYC_4_S       = T_4_S * 1000 * CYC_PER_MS;
  localparam int CYC_1_MS      = T_1_MS * CYC_PER_MS;
  localparam int CYC_2_MS      = T_2_MS * CYC_PER_MS;
  localparam int CYC_4_MS      = T_4_MS * CYC_PER_MS;

  // Number of ramp steps taken after the power-on delay.
  localparam logic [3:0] RAMP_STEPS = 4'h8;

  typedef enum logic [1:0] {
    DRP_IDLE  = 2'b00,
    DRP_DELAY = 2'b01,
    DRP_RAMP  = 2'b10,
    DRP_READY = 2'b11
  } drp_state_type;

endpackage : drp_pkg
`default_nettype wire

/* File: testbench/drp_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module drp_ctrl_asserts
  import drp_pkg::*;
(
  // Clock and register port
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       ce,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Driver sequencing
  input wire logic       drv_power_req,
  input wire logic       drv_ramp_step,
  input wire logic       drv_ready,
  // Routing and volume
  input wire logic       left_mixer_path,
  input wire logic       left_line_path,
  input wire logic       left_direct_hp_path,
  input wire logic       right_mixer_path,
  input wire logic       right_line_path,
  input wire logic       right_direct_hp_path,
  input wire logic       vcm_from_bandgap,
  input wire logic       left_mute,
  input wire logic [7:0] left_atten,
  input wire logic       right_mute,
  input wire logic [7:0] right_atten
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // Derived outputs trail a write by two edges, so the checks look back two cycles.
  function automatic logic [2:0] dec(input logic [7:0] d, input int s);
    return {d[s+:2] == PATH_MIXER, d[s+:2] == PATH_LINE, d[s+:2] == PATH_DIRECT};
  endfunction : dec

  property p_left_route;
    (ce && reg_wr && reg_addr == ADDR_SWITCH) ##1 ce |=>
      {left_mixer_path, left_line_path, left_direct_hp_path} == dec($past(reg_wdata, 2), SW_LEFT_LO);
  endproperty
  a_left_route: assert property (p_left_route) else $error("left route wrong");

  property p_right_route;
    (ce && reg_wr && reg_addr == ADDR_SWITCH) ##1 ce |=>
      {right_mixer_path, right_line_path, right_direct_hp_path} == dec($past(reg_wdata, 2), SW_RIGHT_LO);
  endproperty
  a_right_route: assert property (p_right_route) else $error("right route wrong");

  property p_read_back;
    (ce && reg_wr && reg_addr == ADDR_LEFT_VOL) ##1 (ce && reg_addr == ADDR_LEFT_VOL) |=>
      reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_read_back: assert property (p_read_back) else $error("volume read back wrong");

  property p_reset_vals;
    $fell(srst) |-> left_mixer_path && right_mixer_path && !left_direct_hp_path && !right_line_path
      && left_mute && right_mute && left_atten == 8'h00 && right_atten == 8'h00 && !vcm_from_bandgap;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset outputs wrong");

  property p_vcm;
    (ce && reg_wr && reg_addr == ADDR_POP) ##1 ce |=> vcm_from_bandgap == $past(reg_wdata[POP_VCM_BIT], 2);
  endproperty
  a_vcm: assert property (p_vcm) else $error("vcm select wrong");

  property p_left_follow;
    (ce && reg_wr && reg_addr == ADDR_SWITCH && reg_wdata[1:0] == LINK_LEFT_FOLLOWS && !reg_wdata[7]
      && !reg_wdata[5]) ##1 (ce && !reg_wr) |=> left_mute == right_mute && left_atten == right_atten;
  endproperty
  a_left_follow: assert property (p_left_follow) else $error("left follow wrong");

  property p_right_follow;
    (ce && reg_wr && reg_addr == ADDR_SWITCH && reg_wdata[1:0] == LINK_RIGHT_FOLLOWS && !reg_wdata[7]
      && !reg_wdata[5]) ##1 (ce && !reg_wr) |=> left_mute == right_mute && left_atten == right_atten;
  endproperty
  a_right_follow: assert property (p_right_follow) else $error("right follow wrong");

  property p_direct;
    (ce && reg_wr && reg_addr == ADDR_SWITCH && reg_wdata == 8'h81) ##1 (ce && !reg_wr) |=>
      left_atten == right_atten + DIRECT_EXTRA_ATT;
  endproperty
  a_direct: assert property (p_direct) else $error("direct path gain wrong");

  property p_abort;
    ce && !drv_power_req |=> !drv_ready && !drv_ramp_step;
  endproperty
  a_abort: assert property (p_abort) else $error("driver not down");
endmodule : drp_ctrl_asserts

bind drp_ctrl drp_ctrl_asserts chk_u (.*);
`default_nettype wire

/* File: testbench/drp_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module drp_ctrl_bench
  import drp_pkg::*;
;
  localparam int D100U = 60, D10M = 90, S1 = 20, S2 = 30, S4 = 40;
  logic mclk, srst, ce, reg_wr, drv_power_req, drv_ramp_step, drv_ready, vcm_from_bandgap;
  logic left_mixer_path, left_line_path, left_direct_hp_path, left_mute, right_mute;
  logic right_mixer_path, right_line_path, right_direct_hp_path;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, left_atten, right_atten, a, d;
  logic [31:0] seed = 32'h401DCFCF;
  logic [7:0] ad [5] = '{ADDR_SWITCH, ADDR_POP, ADDR_LEFT_VOL, ADDR_RIGHT_VOL, 8'h30};
  logic [15:0] dir [7] = '{16'h2C7F, 16'h2981, 16'h2B85, 16'h2962, 16'h2912, 16'h2943, 16'h2911};
  int n_errors, num_checks, sw, pop, lv = 128, rv = 128;
  int dl [4] = '{0, CYC_10_US, D100U, D10M};
  int st [4] = '{0, S1, S2, S4};

  drp_ctrl #(.P_DLY_100_US(D100U), .P_DLY_10_MS(D10M), .P_STEP_1_MS(S1), .P_STEP_2_MS(S2),
    .P_STEP_4_MS(S4)) dut_u (.*);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Optional write, then a read of the same address compared with the model of the read data and every routing and volume output.
  task automatic xfer(input logic [7:0] ra, input logic [7:0] rd, input bit we, input bit frz);
    logic [32:0] e, g;
    int lp, rp, ls, rs;
    if (we) begin
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= ra;
      reg_wdata <= rd;
      ce <= !frz;
      if (frz) begin
        @(posedge mclk);
        ce <= 1'b1;
      end
      @(posedge mclk);
      reg_wr <= 1'b0;
      case (ra)
        ADDR_SWITCH: sw = rd;
        ADDR_POP: pop = rd;
        ADDR_LEFT_VOL: lv = rd;
        ADDR_RIGHT_VOL: rv = rd;
        default: ;
      endcase
    end
    // A read alone still changes the address on a clock edge, as every other input does.
    if (!we) @(posedge mclk);
    reg_addr <= ra;
    repeat (2) @(posedge mclk);
    #1;
    lp = sw >> 6 & 3;
    rp = sw >> 4 & 3;
    ls = (sw & 3) == 1 ? rv : lv;
    rs = (sw & 3) == 2 ? lv : rv;
    e[32:25] = 8'(ra == ADDR_SWITCH ? sw : ra == ADDR_POP ? pop : ra == ADDR_LEFT_VOL ? lv :
      ra == ADDR_RIGHT_VOL ? rv : 0);
    e[24:0] = {lp == 0, lp == 1, lp == 2, rp == 0, rp == 1, rp == 2, pop[1], ls[7],
      8'(ls % 128 + (lp == 2 ? 2 : 0)), rs[7], 8'(rs % 128 + (rp == 2 ? 2 : 0))};
    g = {reg_rdata, left_mixer_path, left_line_path, left_direct_hp_path, right_mixer_path, right_line_path,
      right_direct_hp_path, vcm_from_bandgap, left_mute, left_atten, right_mute, right_atten};
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : xfer

  task automatic pw(input logic [7:0] p, input int dd, input int ss);
    int n, k;
    n = 0;
    k = 0;
    xfer(ADDR_POP, p, 1'b1, 1'b0);
    @(posedge mclk);
    drv_power_req <= 1'b1;
    while (drv_ready !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      #1;
      n++;
      k += drv_ramp_step;
    end
    @(posedge mclk);
    drv_power_req <= 1'b0;
    @(posedge mclk);
    #1;
    num_checks++;
    // Load edge, delay plus one edges, eight steps of step plus one edges, then the ready edge.
    if (k != RAMP_STEPS || n != dd + 8 * ss + 11 || drv_ready !== 1'b0) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, n, dd + 8 * ss + 11);
    end
  endtask : pw

  task automatic end_sim();
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // A run still going after 20000 cycles ends as a failure; the driver wait in pw gives up on its own after 3000 cycles.
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    end_sim();
  end

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    drv_power_req = 1'b0;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    for (int j = 0; j < 5; j++) xfer(ad[j], 8'h00, 1'b0, 1'b0);
    foreach (dir[j]) xfer(dir[j][15:8], dir[j][7:0], 1'b1, 1'b0);
    for (int i = 0; i < 80; i++) begin
      seed = lfsr(seed);
      a = ad[i % 5];
      d = seed[7:0];
      if (a == ADDR_SWITCH) d = {d[7:6] % 2'd3, d[5:4] % 2'd3, 2'b00, d[1:0]};
      if (a == ADDR_POP) d = {d[7:4] > 4'hB ? 1'b0 : d[7], d[6:1], 1'b0};
      xfer(a, d, 1'b1, seed[9]);
    end
    // A reset in mid-run must bring back every reset value after random writes.
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    sw = 0;
    pop = 0;
    lv = 128;
    rv = 128;
    for (int j = 0; j < 5; j++) xfer(ad[j], 8'h00, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) pw(8'(k * 8'h14), dl[k], st[k]);
    end_sim();
  end
endmodule : drp_ctrl_bench
`default_nettype wire
